//--- src/module_lowspeed_control.sv
// Overview of operation
// - Answer 2-wire traffic only while module select is low.
// - Reset input held low past minimum length restores all defaults.
// - Completion shown by interrupt low with data-not-ready flag cleared.
// - Power-up posts the completion interrupt without a reset pulse.
// - Low-power input limits the maximum power the module draws.
// - Presence line is pulled to ground while the module is inserted.
// - Interrupt output driven low for faults or critical status.
// - Transmitter off by disable pin, by 2-wire control, or both.
// - Loss alarm set whenever any lane falls below the threshold.
// - Per-lane received power is monitored and readable over 2-wire.
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module module_lowspeed_control
  import lsc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_select_i,
  input wire logic transmit_disable_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic interrupt_n_o,
  output logic interrupt_n_oe_o,
  output logic module_present_n_o,
  output logic module_present_n_oe_o,
  input wire logic [LANES*PWR_W-1:0] lane_power_i,
  output logic tx_off_o,
  output logic power_limit_o,
  output logic receive_loss_alarm_o
);

  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    twi_state_e st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic ptr_set;
    logic [7:0] ptr;
    logic sda_drv;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [31:0] init_cnt;
    logic init_pending;
    logic [7:0] flags;
    logic [7:0] host_mask;
    logic ctrl_txdis;
    logic ctrl_lowpwr;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] thresh;
    logic [LANES-1:0] los_prev;
    logic ack;
    logic [31:0] rdata;
    logic tx_off;
    logic power_limit;
    logic int_drive;
    logic irq;
  } state_s;

  state_s s_q, s_d;

  logic [5:0] pins_s;
  logic scl_s, sda_s, sel_n_s, reset_n_s, lowpwr_s, txdis_s;
  logic [LANES*PWR_W-1:0] power;
  logic [LANES-1:0] below;

  // Reset to idle pin levels, so no false edge or power limit follows reset
  pin_sync #(
    .W(6),
    .RST_VAL(6'h3C)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({scl_i, sda_i, module_select_n_i, module_reset_n_i,
             low_power_select_i, transmit_disable_i}),
    .sync_o(pins_s)
  );

  assign {scl_s, sda_s, sel_n_s, reset_n_s, lowpwr_s, txdis_s} = pins_s;

  lane_monitor #(
    .N(LANES),
    .PW(PWR_W)
  ) u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lane_power_i(lane_power_i),
    .thresh_i(s_q.thresh),
    .power_o(power),
    .below_o(below)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : merge

  logic scl_rise, scl_fall, start_c, stop_c;
  logic wb_req, wb_wr;
  logic [7:0] status_byte;
  logic [7:0] rbyte;
  logic [LANES-1:0] los_rise;
  logic [7:0] flag_set;
  logic flag_clr;
  logic twi_wr;
  logic [7:0] twi_wr_byte;
  logic [31:0] m32;
  logic full_reset;
  logic init_done;

  always_comb begin
    scl_rise = scl_s & ~s_q.scl_prev;
    scl_fall = ~scl_s & s_q.scl_prev;
    start_c = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
    stop_c = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
    wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wb_wr = wb_req & wb_we_i;
    status_byte = {4'h0, s_q.power_limit, s_q.tx_off, |below, s_q.init_pending};
    los_rise = below & ~s_q.los_prev;
    init_done = s_q.init_pending && (s_q.init_cnt == INIT_CYCLES - 1);
    full_reset = ~reset_n_s && (s_q.rst_cnt == RST_CNT_W'(RESET_MIN_CYC));
    rbyte = 8'h00;
    unique case (s_q.ptr)
      TM_STATUS: rbyte = status_byte;
      TM_FLAGS: rbyte = s_q.flags;
      TM_CONTROL: rbyte = {7'h00, s_q.ctrl_txdis};
      TM_MASK: rbyte = s_q.host_mask;
      default: begin
        for (int i = 0; i < 2 * LANES; i++) begin
          if (s_q.ptr == TM_LANE0 + 8'(i)) begin
            rbyte = (i % 2 == 0) ? power[(i/2)*PWR_W + 8 +: 8] : power[(i/2)*PWR_W +: 8];
          end
        end
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    flag_set = 8'h00;
    flag_clr = 1'b0;
    twi_wr = 1'b0;
    twi_wr_byte = s_q.shreg;
    m32 = 32'h0000_0000;
    s_d.scl_prev = scl_s;
    s_d.sda_prev = sda_s;
    s_d.los_prev = below;

    // 2-wire slave; edges come from the synchronised pins only
    if (start_c) begin
      s_d.st = TW_ADDR;
      s_d.cnt = 4'h0;
      s_d.ptr_set = 1'b0;
      s_d.sda_drv = 1'b0;
    end else if (stop_c) begin
      s_d.st = TW_IDLE;
      s_d.sda_drv = 1'b0;
    end else begin
      unique case (s_q.st)
        TW_IDLE: s_d.sda_drv = 1'b0;
        TW_ADDR, TW_WRITE: begin
          if (scl_rise) begin
            s_d.shreg = {s_q.shreg[6:0], sda_s};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall && s_q.cnt == 4'h8) begin
            if (s_q.st == TW_WRITE) begin
              twi_wr = 1'b1;
              s_d.st = TW_ACK;
              s_d.sda_drv = 1'b1;
            end else if (s_q.shreg[7:1] == TWI_DEV_ADDR) begin
              s_d.rw = s_q.shreg[0];
              s_d.st = TW_ACK;
              s_d.sda_drv = 1'b1;
            end else begin
              s_d.st = TW_IDLE;
            end
          end
        end
        TW_ACK: begin
          if (scl_fall) begin
            s_d.cnt = 4'h0;
            if (s_q.rw) begin
              s_d.st = TW_READ;
              s_d.shreg = {rbyte[6:0], 1'b0};
              s_d.sda_drv = ~rbyte[7];
              flag_clr = (s_q.ptr == TM_FLAGS);
              s_d.ptr = s_q.ptr + 8'h01;
            end else begin
              s_d.st = TW_WRITE;
              s_d.sda_drv = 1'b0;
            end
          end
        end
        TW_READ: begin
          if (scl_rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_q.cnt == 4'h8) begin
              s_d.st = TW_RACK;
              s_d.sda_drv = 1'b0;
            end else begin
              s_d.sda_drv = ~s_q.shreg[7];
              s_d.shreg = {s_q.shreg[6:0], 1'b0};
            end
          end
        end
        TW_RACK: begin
          if (scl_rise && sda_s) begin
            s_d.st = TW_IDLE;
          end else if (scl_fall) begin
            s_d.st = TW_ACK;
            s_d.rw = 1'b1;
          end
        end
        default: s_d.st = TW_IDLE;
      endcase
    end

    // deselected module lets go of the bus
    if (sel_n_s) begin
      s_d.st = TW_IDLE;
      s_d.sda_drv = 1'b0;
      twi_wr = 1'b0;
      flag_clr = 1'b0;
    end

    // First data byte of a write sets the pointer
    if (twi_wr) begin
      if (!s_q.ptr_set) begin
        s_d.ptr_set = 1'b1;
        s_d.ptr = twi_wr_byte;
      end else begin
        s_d.ptr = s_q.ptr + 8'h01;
        if (s_q.ptr == TM_CONTROL) begin
          s_d.ctrl_txdis = twi_wr_byte[0];
        end
        if (s_q.ptr == TM_MASK) begin
          s_d.host_mask = twi_wr_byte;
        end
      end
    end

    if (s_q.init_pending) begin
      s_d.init_cnt = s_q.init_cnt + 32'h1;
    end
    if (init_done) begin
      s_d.init_pending = 1'b0;
      flag_set[FL_RESET_DONE] = 1'b1;
    end
    flag_set[FL_LOS0 +: LANES] = los_rise;
    // clear on read, a new event wins
    s_d.flags = ((flag_clr ? 8'h00 : s_q.flags)) | flag_set;

    // Wishbone slave: one wait-free ack per request
    s_d.ack = wb_req;
    if (wb_req) begin
      unique case (wb_adr_i)
        WB_CTRL: m32 = {30'h0, s_q.ctrl_lowpwr, s_q.ctrl_txdis};
        WB_STATUS: m32 = {24'h0, status_byte};
        WB_IRQ_STATUS: m32 = {{(32 - IRQ_W){1'b0}}, s_q.irq_status};
        WB_IRQ_MASK: m32 = {{(32 - IRQ_W){1'b0}}, s_q.irq_mask};
        WB_LOS_THRESH: m32 = {16'h0, s_q.thresh};
        WB_LANE01: m32 = {power[PWR_W +: PWR_W], power[0 +: PWR_W]};
        WB_LANE23: m32 = {power[3*PWR_W +: PWR_W], power[2*PWR_W +: PWR_W]};
        default: m32 = 32'h0000_0000;
      endcase
      s_d.rdata = wb_we_i ? 32'h0000_0000 : m32;
    end
    if (wb_wr) begin
      unique case (wb_adr_i)
        WB_CTRL: begin
          m32 = merge({30'h0, s_q.ctrl_lowpwr, s_q.ctrl_txdis}, wb_dat_i, wb_sel_i);
          s_d.ctrl_txdis = m32[CTRL_TXDIS];
          s_d.ctrl_lowpwr = m32[CTRL_LOWPWR];
        end
        WB_IRQ_MASK: begin
          m32 = merge({{(32 - IRQ_W){1'b0}}, s_q.irq_mask}, wb_dat_i, wb_sel_i);
          s_d.irq_mask = m32[IRQ_W-1:0];
        end
        WB_LOS_THRESH: begin
          m32 = merge({16'h0, s_q.thresh}, wb_dat_i, wb_sel_i);
          s_d.thresh = m32[15:0];
        end
        default: ;
      endcase
    end
    // Write-one-to-clear; a same-cycle event keeps its bit
    s_d.irq_status = s_q.irq_status
                     & ~((wb_wr && wb_adr_i == WB_IRQ_STATUS && wb_sel_i[0])
                         ? wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}})
                     | {twi_wr & s_q.ptr_set, |los_rise, init_done};

    // either source, or a pending init, turns the transmitter off
    s_d.tx_off = txdis_s | s_q.ctrl_txdis | s_q.init_pending;
    s_d.power_limit = lowpwr_s | s_q.ctrl_lowpwr;
    // pull interrupt low on unmasked flags, held off during init
    s_d.int_drive = |(s_d.flags & ~s_q.host_mask) & ~s_q.init_pending;
    s_d.irq = |(s_q.irq_status & s_q.irq_mask);

    // Reset pulse length counter
    if (reset_n_s) begin
      s_d.rst_cnt = '0;
    end else if (!full_reset) begin
      s_d.rst_cnt = s_q.rst_cnt + RST_CNT_W'(1);
    end

    // full reset; the same on power-up
    if (full_reset || rst_i) begin
      s_d = '0;
      s_d.st = TW_IDLE;
      s_d.scl_prev = 1'b1;
      s_d.sda_prev = 1'b1;
      s_d.thresh = LOS_THRESH_RST;
      s_d.los_prev = rst_i ? '0 : below;
      // not-ready from the start of reset
      s_d.init_pending = 1'b1;
      s_d.tx_off = 1'b1;
      s_d.power_limit = rst_i ? 1'b0 : lowpwr_s;
      s_d.rst_cnt = rst_i ? '0 : s_q.rst_cnt;
      s_d.ack = rst_i ? 1'b0 : wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign irq_o = s_q.irq;
  assign sda_o = 1'b0;
  assign sda_oe_o = s_q.sda_drv;
  assign interrupt_n_o = 1'b0;
  assign interrupt_n_oe_o = s_q.int_drive;
  assign module_present_n_o = 1'b0;
  assign module_present_n_oe_o = 1'b1;
  assign tx_off_o = s_q.tx_off;
  assign power_limit_o = s_q.power_limit;
  assign receive_loss_alarm_o = |below;

endmodule : module_lowspeed_control

//--- src/lsc_pkg.sv
package lsc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LANES = 4;
  localparam int unsigned PWR_W = 16;

  // Timing
  localparam int unsigned RESET_MIN_NS = 10000;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = $clog2(RESET_MIN_CYC + 1);
  localparam longint unsigned INIT_TIME_MS = 2000;
  localparam int unsigned INIT_CYC = int'(INIT_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);

  // Wishbone register byte offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_IRQ_STATUS = 8'h08;
  localparam logic [7:0] WB_IRQ_MASK = 8'h0C;
  localparam logic [7:0] WB_LOS_THRESH = 8'h10;
  localparam logic [7:0] WB_LANE01 = 8'h14;
  localparam logic [7:0] WB_LANE23 = 8'h18;

  // Wishbone field positions
  localparam int unsigned CTRL_TXDIS = 0;
  localparam int unsigned CTRL_LOWPWR = 1;
  localparam int unsigned IRQ_INIT_DONE = 0;
  localparam int unsigned IRQ_LOS = 1;
  localparam int unsigned IRQ_TWI_WR = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [15:0] LOS_THRESH_RST = 16'h0100;

  // 2-wire map byte indices
  localparam logic [6:0] TWI_DEV_ADDR = 7'h50;
  localparam logic [7:0] TM_STATUS = 8'h00;
  localparam logic [7:0] TM_FLAGS = 8'h01;
  localparam logic [7:0] TM_CONTROL = 8'h02;
  localparam logic [7:0] TM_MASK = 8'h03;
  localparam logic [7:0] TM_LANE0 = 8'h04;
  // Status bits: 0 data not ready, 1 loss alarm, 2 tx off, 3 power limit
  localparam int unsigned ST_NOT_READY = 0;
  // Flag bits: 0 reset complete, 2..5 per-lane loss latched
  localparam int unsigned FL_RESET_DONE = 0;
  localparam int unsigned FL_LOS0 = 2;

  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_WRITE, TW_ACK, TW_READ, TW_RACK
  } twi_state_e;

endpackage : lsc_pkg

//--- src/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s s_q, s_d;

  always_comb begin
    s_d.s1 = pins_i;
    s_d.s2 = s_q.s1;
    if (rst_i) begin
      s_d.s1 = RST_VAL;
      s_d.s2 = RST_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign sync_o = s_q.s2;
endmodule : pin_sync

//--- src/lane_monitor.sv
`timescale 1ns/100ps
module lane_monitor
  import lsc_pkg::*;
#(
  parameter int unsigned N = LANES,
  parameter int unsigned PW = PWR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N*PW-1:0] lane_power_i,
  input wire logic [PW-1:0] thresh_i,
  output logic [N*PW-1:0] power_o,
  output logic [N-1:0] below_o
);
  typedef struct packed {
    logic [N*PW-1:0] power;
    logic [N-1:0] below;
  } mon_s;

  mon_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      s_d.power[i*PW +: PW] = lane_power_i[i*PW +: PW];
      s_d.below[i] = lane_power_i[i*PW +: PW] < thresh_i;
    end
    if (rst_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign power_o = s_q.power;
  assign below_o = s_q.below;
endmodule : lane_monitor

//--- testbench/lsc_checker_assertions.sv
`timescale 1ns/100ps
module lsc_checker
  import lsc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_select_i,
  input wire logic transmit_disable_i,
  input wire logic sda_oe_o,
  input wire logic interrupt_n_o,
  input wire logic interrupt_n_oe_o,
  input wire logic module_present_n_o,
  input wire logic module_present_n_oe_o,
  input wire logic [LANES*PWR_W-1:0] lane_power_i,
  input wire logic tx_off_o,
  input wire logic power_limit_o,
  input wire logic receive_loss_alarm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counts raw pin low time; margin covers the pin synchroniser
  logic [10:0] low_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || module_reset_n_i) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + 11'h001;
    end
  end
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held over one cycle");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
  property p_sel; module_select_n_i [*6] |-> !sda_oe_o; endproperty
  a_sel: assert property (p_sel) else $error("data line driven while deselected");
  property p_txdis; transmit_disable_i [*5] |-> tx_off_o; endproperty
  a_txdis: assert property (p_txdis) else $error("transmitter on while disabled");
  property p_lowpwr; low_power_select_i [*5] |-> power_limit_o; endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("power not limited");
  property p_noloss; (lane_power_i == '1) [*3] |-> !receive_loss_alarm_o; endproperty
  a_noloss: assert property (p_noloss) else $error("loss alarm at full power");
  property p_present; module_present_n_oe_o && !module_present_n_o; endproperty
  a_present: assert property (p_present) else $error("presence line not grounded");
  property p_intpin; interrupt_n_oe_o |-> !interrupt_n_o; endproperty
  a_intpin: assert property (p_intpin) else $error("interrupt line not low");
  property p_modrst;
    low_cnt_q > 11'(RESET_MIN_CYC + 8) |-> tx_off_o && !interrupt_n_oe_o;
  endproperty
  a_modrst: assert property (p_modrst) else $error("module reset not applied");
  c_int: cover property ($rose(interrupt_n_oe_o));
  c_loss: cover property ($rose(receive_loss_alarm_o));
  c_modrst: cover property (low_cnt_q == 11'(RESET_MIN_CYC + 9));
endmodule : lsc_checker

bind module_lowspeed_control lsc_checker #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .module_select_n_i, .module_reset_n_i,
  .low_power_select_i, .transmit_disable_i, .sda_oe_o, .interrupt_n_o, .interrupt_n_oe_o,
  .module_present_n_o, .module_present_n_oe_o, .lane_power_i, .tx_off_o, .power_limit_o,
  .receive_loss_alarm_o
);

//--- testbench/host_twi.sv
`timescale 1ns/100ps
module host_twi
  import lsc_pkg::*;
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Clock stands high between frames; data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    sda_low_o = !b;
    #20 scl_o = 1'b1;
    #20 r = sda_i;
    #20 scl_o = 1'b0;
    #20;
  endtask : bitx
  task automatic start();
    #3 sda_low_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    #20 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #40;
  endtask : stop
  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ok = ok & !r;
  endtask : wbyte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    wbyte({TWI_DEV_ADDR, 1'b0}, ok);
    wbyte(ptr, ok);
    wbyte(d, ok);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    start();
    wbyte({TWI_DEV_ADDR, 1'b0}, ok);
    wbyte(ptr, ok);
    start();
    wbyte({TWI_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
    stop();
  endtask : rd
endmodule : host_twi

//--- testbench/tb_module_lowspeed_control.sv
`timescale 1ns/100ps
module tb_module_lowspeed_control
  import lsc_pkg::*;
;
  localparam int unsigned INIT = 50;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
  logic wb_ack_o, irq_o, sda_o, sda_oe_o, interrupt_n_o, interrupt_n_oe_o, scl_i, sda_i;
  logic module_present_n_o, module_present_n_oe_o, tx_off_o, power_limit_o;
  logic receive_loss_alarm_o, host_sda_low, twi_ok;
  logic module_select_n_i = 1'b0, module_reset_n_i = 1'b1;
  logic low_power_select_i = 1'b0, transmit_disable_i = 1'b0;
  logic [LANES*PWR_W-1:0] lane_power_i = {4{16'h0400}};
  logic [7:0] twi_byte;
  int err_count = 0, num_checks = 0, cycles = 0;
  // Shared data line with host pull-up
  assign sda_i = !(host_sda_low || (sda_oe_o && !sda_o));
  always #5 clk_i = !clk_i;
  module_lowspeed_control #(.INIT_CYCLES(INIT)) dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .module_select_n_i, .module_reset_n_i, .low_power_select_i,
    .transmit_disable_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .interrupt_n_o, .interrupt_n_oe_o,
    .module_present_n_o, .module_present_n_oe_o, .lane_power_i, .tx_off_o, .power_limit_o,
    .receive_loss_alarm_o
  );
  host_twi host_u (.sda_i(sda_i), .scl_o(scl_i), .sda_low_o(host_sda_low));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wait_int();
    int n;
    n = 0;
    while (interrupt_n_oe_o !== 1'b1 && n < INIT + 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(n < INIT + 40, 1, "completion interrupt");
  endtask : wait_int
  task automatic t_reset();
    chk(tx_off_o, 1, "tx off after reset");
    chk(interrupt_n_oe_o, 0, "interrupt withheld");
    chk({module_present_n_oe_o, module_present_n_o}, 2, "presence");
    wb(0, WB_STATUS, 0);
    chk(rd_q[ST_NOT_READY], 1, "not ready");
    wb(0, WB_LOS_THRESH, 0);
    chk(rd_q, {16'h0, LOS_THRESH_RST}, "threshold default");
    wb(1, 8'h40, 32'hFFFF_FFFF);
    wb(0, 8'h40, 0);
    chk(rd_q, 0, "unmapped");
    $display("test reset finished");
  endtask : t_reset
  task automatic t_init();
    wait_int();
    wb(0, WB_STATUS, 0);
    chk(rd_q[ST_NOT_READY], 0, "ready");
    wb(0, WB_IRQ_STATUS, 0);
    chk(rd_q[IRQ_INIT_DONE], 1, "init event");
    chk(irq_o, 0, "masked irq");
    wb(1, WB_IRQ_MASK, 1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1, "unmasked irq");
    wb(1, WB_IRQ_STATUS, 1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0, "cleared irq");
    host_u.rd(TM_FLAGS, twi_byte, twi_ok);
    chk({twi_ok, twi_byte[FL_RESET_DONE]}, 3, "flag read");
    chk(interrupt_n_oe_o, 0, "interrupt released");
    $display("test init finished");
  endtask : t_init
  task automatic t_select();
    // select high: another module owns the bus
    @(posedge clk_i);
    module_select_n_i <= 1'b1;
    host_u.rd(TM_STATUS, twi_byte, twi_ok);
    chk(twi_ok, 0, "deselected ignored");
    @(posedge clk_i);
    module_select_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    host_u.rd(TM_STATUS, twi_byte, twi_ok);
    chk({twi_ok, twi_byte[ST_NOT_READY]}, 2, "selected answer");
    $display("test select finished");
  endtask : t_select
  task automatic t_txpwr();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      transmit_disable_i <= i[0];
      low_power_select_i <= i[0];
      wb(1, WB_CTRL, {30'h0, i[1], i[1]});
      repeat (6) @(posedge clk_i);
      chk(tx_off_o, |i[1:0], "tx off");
      chk(power_limit_o, |i[1:0], "power limit");
    end
    transmit_disable_i <= 1'b0;
    low_power_select_i <= 1'b0;
    wb(1, WB_CTRL, 0);
    host_u.wr(TM_CONTROL, 8'h01, twi_ok);
    chk({twi_ok, tx_off_o}, 3, "2-wire tx off");
    host_u.wr(TM_CONTROL, 8'h00, twi_ok);
    chk({twi_ok, tx_off_o}, 2, "2-wire tx on");
    $display("test tx and power finished");
  endtask : t_txpwr
  task automatic t_los();
    wb(1, WB_IRQ_MASK, 32'h2);
    lane_power_i <= {16'h0100, 16'h0300, 16'h0200, 16'h00FF};
    repeat (4) @(posedge clk_i);
    chk(receive_loss_alarm_o, 1, "lane below");
    chk(irq_o, 1, "loss irq");
    chk(interrupt_n_oe_o, 1, "loss interrupt pin");
    wb(0, WB_LANE01, 0);
    chk(rd_q, 32'h0200_00FF, "lanes 1:0");
    wb(0, WB_LANE23, 0);
    chk(rd_q, 32'h0100_0300, "lanes 3:2");
    host_u.rd(TM_LANE0 + 8'h01, twi_byte, twi_ok);
    chk({twi_ok, twi_byte}, 9'h1FF, "lane0 low byte");
    host_u.wr(TM_MASK, 8'hFF, twi_ok);
    chk({twi_ok, interrupt_n_oe_o}, 2, "host mask");
    @(posedge clk_i);
    lane_power_i <= {16'h0100, 16'h0300, 16'h0200, 16'h0100};
    repeat (4) @(posedge clk_i);
    chk(receive_loss_alarm_o, 0, "at threshold");
    wb(1, WB_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0, "loss irq cleared");
    lane_power_i <= '1;
    repeat (4) @(posedge clk_i);
    chk(receive_loss_alarm_o, 0, "full power");
    $display("test loss finished");
  endtask : t_los
  task automatic t_modreset();
    wb(1, WB_CTRL, 32'h2);
    @(posedge clk_i);
    module_reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    module_reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(power_limit_o, 1, "short pulse ignored");
    module_reset_n_i <= 1'b0;
    repeat (RESET_MIN_CYC + 20) @(posedge clk_i);
    module_reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({power_limit_o, interrupt_n_oe_o}, 0, "defaults, withheld");
    wb(0, WB_CTRL, 0);
    chk(rd_q, 0, "control default");
    wb(0, WB_IRQ_MASK, 0);
    chk(rd_q, 0, "mask default");
    wb(0, WB_STATUS, 0);
    chk(rd_q[ST_NOT_READY], 1, "not ready again");
    wait_int();
    $display("test module reset finished");
  endtask : t_modreset
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_init();
    t_select();
    t_txpwr();
    t_los();
    t_modreset();
    tally_and_finish();
  end
endmodule : tb_module_lowspeed_control
